// ### logic/lmb_port.sv
// Purpose: axi4-lite port onto two alternating 96-byte message buffers
// Assumes: hdlc controllers sit outside; flags arrive as same-clock levels
// Notes:   buffer 1 is the documented window, buffer 0 its twin
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module lmb_port
  import lmb_pkg::*;
#(
  parameter int DEPTH = lmb_pkg::LMB_DEPTH
) (
  input  wire  logic         aclk,
  input  wire  logic         aresetn,
  input  wire  logic         clk_en,
  input  wire  logic [11:0]  s_axi_awaddr,
  input  wire  logic         s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire  logic [31:0]  s_axi_wdata,
  input  wire  logic [3:0]   s_axi_wstrb,
  input  wire  logic         s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire  logic         s_axi_bready,
  input  wire  logic [11:0]  s_axi_araddr,
  input  wire  logic         s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire  logic         s_axi_rready,
  input  wire  logic         tx_buffer_free_flag,
  input  wire  logic         rx_buffer_pointer_flag,
  input  wire  logic         rx_end_of_transfer_irq,
  input  wire  logic         tx_msg_taken,
  input  wire  logic [6:0]   hdlc_addr,
  input  wire  logic         hdlc_wr,
  input  wire  logic [7:0]   hdlc_wdata,
  output logic [7:0]         hdlc_rdata,
  output logic [1:0]         ctrl_select
);
  import lmb_pkg::*;

  logic [7:0]           mem0 [DEPTH];
  logic [7:0]           mem1 [DEPTH];
  logic [LMB_PTR_W-1:0] ptr0, ptr1, next_ptr0, next_ptr1;
  logic [1:0]           sel, next_sel;
  logic                 aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [11:0]          aw_q, next_aw_q;
  logic [7:0]           wd_q, next_wd_q;
  logic                 wstb_q, next_wstb_q;
  logic                 bv, next_bv, rv, next_rv;
  logic [1:0]           bresp_q, next_bresp_q, rresp_q, next_rresp_q;
  logic [31:0]          rdata_q, next_rdata_q;
  logic                 eot_d, tx_d;
  logic                 wr_go, rd_go, wr0, wr1;
  logic [7:0]           hrd_q;
  logic                 awrdy_q, next_awrdy_q;
  logic                 wrdy_q, next_wrdy_q;
  logic                 arrdy_q, next_arrdy_q;
  logic                 hdlc_in;

  // readies kept in flops so no bus output passes through gates
  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_bvalid  = bv;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rv;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign ctrl_select   = sel;
  assign hdlc_rdata    = hrd_q;

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_q    = aw_q;
    next_wd_q    = wd_q;
    next_wstb_q  = wstb_q;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_q    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_wd_q   = s_axi_wdata[7:0];
      next_wstb_q = s_axi_wstrb[0];
    end
    wr_go = next_aw_hold & next_w_hold & ~bv;
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
    end
  end

  // byte lane 0 only; other lanes ignored
  assign wr0   = wr_go && next_aw_q == LMB_BUF0_OFF && next_wstb_q;
  assign wr1   = wr_go && next_aw_q == LMB_BUF1_OFF && next_wstb_q;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  // controller addresses past the last byte are dropped, not aliased
  assign hdlc_in = hdlc_addr < LMB_PTR_W'(DEPTH);

  always_comb begin
    next_bv      = bv & ~s_axi_bready;
    next_bresp_q = bresp_q;
    next_sel     = sel;
    next_rv      = rv & ~s_axi_rready;
    next_rresp_q = rresp_q;
    next_rdata_q = rdata_q;
    next_ptr0    = ptr0;
    next_ptr1    = ptr1;
    if (wr_go) begin
      next_bv      = 1'b1;
      next_bresp_q = LMB_RESP_OKAY;
      if (next_aw_q == LMB_BUF0_OFF) begin
        next_ptr0 = (ptr0 == LMB_PTR_W'(DEPTH - 1)) ? LMB_PTR_RST : ptr0 + 1'b1;
      end else if (next_aw_q == LMB_BUF1_OFF) begin
        next_ptr1 = (ptr1 == LMB_PTR_W'(DEPTH - 1)) ? LMB_PTR_RST : ptr1 + 1'b1;
      end else if (next_aw_q == LMB_CTRL_OFF) begin
        if (next_wstb_q) next_sel = next_wd_q[1:0];
      end else begin
        next_bresp_q = LMB_RESP_SLVERR;
      end
    end
    if (rd_go) begin
      next_rv      = 1'b1;
      next_rresp_q = LMB_RESP_OKAY;
      next_rdata_q = 32'h0000_0000;
      if (s_axi_araddr == LMB_BUF0_OFF) begin
        next_rdata_q[7:0] = mem0[ptr0];
        next_ptr0 = (ptr0 == LMB_PTR_W'(DEPTH - 1)) ? LMB_PTR_RST : ptr0 + 1'b1;
      end else if (s_axi_araddr == LMB_BUF1_OFF) begin
        next_rdata_q[7:0] = mem1[ptr1];
        next_ptr1 = (ptr1 == LMB_PTR_W'(DEPTH - 1)) ? LMB_PTR_RST : ptr1 + 1'b1;
      end else if (s_axi_araddr == LMB_CTRL_OFF) begin
        next_rdata_q[1:0] = sel;
      end else if (s_axi_araddr == LMB_STAT_OFF) begin
        next_rdata_q[LMB_TX_FREE_BIT]   = tx_buffer_free_flag;
        next_rdata_q[LMB_RX_PTR_BIT+8]  = rx_buffer_pointer_flag;
        next_rdata_q[6:0]               = ptr0;
        next_rdata_q[14:8]              = ptr1;
      end else begin
        next_rresp_q = LMB_RESP_SLVERR;
      end
    end
    // rewind on hand-over; sent bytes are simply overwritten later
    if (rx_end_of_transfer_irq && !eot_d) begin
      if (rx_buffer_pointer_flag) next_ptr1 = LMB_PTR_RST;
      else next_ptr0 = LMB_PTR_RST;
    end
    if (tx_msg_taken && !tx_d) begin
      if (tx_buffer_free_flag) next_ptr1 = LMB_PTR_RST;
      else next_ptr0 = LMB_PTR_RST;
    end
    next_awrdy_q = ~next_aw_hold & ~next_bv;
    next_wrdy_q  = ~next_w_hold & ~next_bv;
    next_arrdy_q = ~next_rv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr0    <= LMB_PTR_RST;
      ptr1    <= LMB_PTR_RST;
      sel     <= LMB_SEL_RST;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_q    <= 12'h000;
      wd_q    <= LMB_BYTE_RST;
      wstb_q  <= 1'b0;
      bv      <= 1'b0;
      rv      <= 1'b0;
      bresp_q <= LMB_RESP_OKAY;
      rresp_q <= LMB_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      eot_d   <= 1'b0;
      tx_d    <= 1'b0;
      hrd_q   <= LMB_BYTE_RST;
      awrdy_q <= 1'b1;
      wrdy_q  <= 1'b1;
      arrdy_q <= 1'b1;
    end else if (clk_en) begin
      ptr0    <= next_ptr0;
      ptr1    <= next_ptr1;
      sel     <= next_sel;
      aw_hold <= next_aw_hold;
      w_hold  <= next_w_hold;
      aw_q    <= next_aw_q;
      wd_q    <= next_wd_q;
      wstb_q  <= next_wstb_q;
      bv      <= next_bv;
      rv      <= next_rv;
      bresp_q <= next_bresp_q;
      rresp_q <= next_rresp_q;
      rdata_q <= next_rdata_q;
      eot_d   <= rx_end_of_transfer_irq;
      tx_d    <= tx_msg_taken;
      hrd_q   <= rx_buffer_pointer_flag ? mem1[hdlc_addr] : mem0[hdlc_addr];
      awrdy_q <= next_awrdy_q;
      wrdy_q  <= next_wrdy_q;
      arrdy_q <= next_arrdy_q;
    end
  end

  // memories carry no reset; software byte writes win over hdlc writes
  always_ff @(posedge aclk) begin
    if (clk_en) begin
      if (wr1) mem1[ptr1] <= next_wd_q;
      else if (hdlc_wr && hdlc_in && rx_buffer_pointer_flag) mem1[hdlc_addr] <= hdlc_wdata;
      if (wr0) mem0[ptr0] <= next_wd_q;
      else if (hdlc_wr && hdlc_in && !rx_buffer_pointer_flag) mem0[hdlc_addr] <= hdlc_wdata;
    end
  end
endmodule

// ### logic/lmb_pkg.sv
// Purpose: constants for the signalling-link message buffer port
// Assumes: axi4-lite, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package lmb_pkg;
  localparam int          LMB_DEPTH         = 96;
  localparam int          LMB_PTR_W         = 7;
  localparam logic [11:0] LMB_BUF0_OFF      = 12'h600;
  localparam logic [11:0] LMB_BUF1_OFF      = 12'h700;
  localparam logic [11:0] LMB_CTRL_OFF      = 12'h710;
  localparam logic [11:0] LMB_STAT_OFF      = 12'h714;
  localparam logic [6:0]  LMB_PTR_RST       = 7'h00;
  localparam logic [7:0]  LMB_BYTE_RST      = 8'h00;
  localparam logic [1:0]  LMB_SEL_RST       = 2'h0;
  localparam int          LMB_TX_FREE_BIT   = 7;
  localparam int          LMB_RX_PTR_BIT    = 7;
  localparam logic [1:0]  LMB_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  LMB_RESP_SLVERR   = 2'b10;
endpackage

// ### verif/lmb_port_chk_asserts.sv
// Purpose: handshake and reset checks on the buffer port
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every lmb_port instance
`timescale 1ns/100ps
module lmb_port_chk
  import lmb_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       clk_en,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] ctrl_select
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire both_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & clk_en;
  wire ar_go   = s_axi_arvalid & s_axi_arready & clk_en;
  property p_wr_resp; both_go |=> s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_rd_resp; ar_go |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");
  property p_b_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_blk: assert property (p_b_blk) else $error("write taken under response");
  property p_r_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_blk: assert property (p_r_blk) else $error("read taken under response");
  property p_b_done; s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_r_done; s_axi_rvalid && s_axi_rready && clk_en |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read response repeated");
  property p_rst_idle; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("response after reset");
  property p_rst_sel; $rose(aresetn) |-> ctrl_select == LMB_SEL_RST; endproperty
  a_rst_sel: assert property (p_rst_sel) else $error("select not cleared");
endmodule
bind lmb_port lmb_port_chk lmb_port_chk_i (.*);

// ### verif/tb.sv
// Purpose: directed register-level run of the buffer port
// Assumes: bready and rready held high, so every answer is taken at once
// Notes:   flags and controller-side pins driven by hand
`timescale 1ns/100ps
module tb;
  import lmb_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, txf = 0, rxf = 0, irq = 0;
  logic taken = 0, hwr = 0, en = 1, awr, wrr, bv, arr, rv;
  logic [3:0]  ws = 4'h1;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, d;
  logic [6:0]  ha = 0;
  logic [7:0]  hwd = 0, hrd;
  logic [1:0]  resp, br, rr, sel;
  int          n_fail = 0, n_tests = 0;
  always #25 aclk = ~aclk;
  lmb_port lmb_port_i (.aclk(aclk), .aresetn(aresetn), .clk_en(en), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .tx_buffer_free_flag(txf), .rx_buffer_pointer_flag(rxf), .rx_end_of_transfer_irq(irq),
    .tx_msg_taken(taken), .hdlc_addr(ha), .hdlc_wr(hwr), .hdlc_wdata(hwd),
    .hdlc_rdata(hrd), .ctrl_select(sel));
  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  // aw and w offered together, each released on its own handshake
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic pa, pw, ta, tw;
    pa = 1;
    pw = 1;
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1;
    wv <= 1;
    while (pa | pw) begin
      @(negedge aclk);
      ta = pa & awr;
      tw = pw & wrr;
      @(posedge aclk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    do @(negedge aclk); while (!bv);
    resp = br;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a);
    ara <= a;
    arv <= 1;
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 0;
    do @(negedge aclk); while (!rv);
    d = rdat;
    resp = rr;
    @(posedge aclk);
  endtask
  // one cycle of controller-side read latency
  task automatic hchk(input logic [6:0] a, input logic [7:0] e);
    ha <= a;
    @(posedge aclk);
    @(negedge aclk);
    chk("hdlc byte", hrd, e);
    @(posedge aclk);
  endtask
  initial begin
    repeat (3000) @(posedge aclk);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(LMB_STAT_OFF);
    chk("status", d, 32'h0);
    wr(LMB_CTRL_OFF, 8'h02);
    chk("select", sel, 2'h2);
    txf <= 1;
    rxf <= 1;
    rd(LMB_STAT_OFF);
    chk("tx free", d, 32'h8080);
    for (int i = 0; i < 4; i++) wr(LMB_BUF1_OFF, 8'h10 + i[7:0]);
    chk("wr resp", resp, LMB_RESP_OKAY);
    for (int i = 0; i < 4; i++) hchk(i[6:0], 8'h10 + i[7:0]);
    rd(LMB_STAT_OFF);
    chk("ptr1", d, 32'h8480);
    for (int i = 0; i < 4; i++) begin
      ha <= i[6:0];
      hwd <= 8'ha0 + i[7:0];
      hwr <= 1;
      @(posedge aclk);
    end
    hwr <= 0;
    irq <= 1;
    repeat (2) @(posedge aclk);
    irq <= 0;
    repeat (2) @(posedge aclk);
    rd(LMB_STAT_OFF);
    chk("rx ptr", d, 32'h8080);
    for (int i = 0; i < 4; i++) begin
      rd(LMB_BUF1_OFF);
      chk("rx byte", d[7:0], 8'ha0 + i[7:0]);
    end
    taken <= 1;
    repeat (2) @(posedge aclk);
    taken <= 0;
    rd(LMB_STAT_OFF);
    chk("tx rewind", d, 32'h8080);
    txf <= 0;
    rxf <= 0;
    for (int i = 0; i < 96; i++) wr(LMB_BUF0_OFF, i[7:0] + 8'h01);
    rd(LMB_STAT_OFF);
    chk("wrap", d, 32'h0);
    hchk(7'd95, 8'd96);
    // controller write while frozen must not land
    en <= 0;
    ha <= 7'd0;
    hwd <= 8'hee;
    hwr <= 1;
    repeat (2) @(posedge aclk);
    hwr <= 0;
    en <= 1;
    rd(LMB_BUF0_OFF);
    chk("first", d[7:0], 8'h01);
    // lane 0 strobe low: pointer moves, byte kept
    ws <= 4'h0;
    wr(LMB_BUF0_OFF, 8'haa);
    ws <= 4'h1;
    hchk(7'd1, 8'h02);
    wr(12'h7fc, 8'h55);
    chk("bad wr", resp, LMB_RESP_SLVERR);
    rd(12'h7fc);
    chk("bad rd", resp, LMB_RESP_SLVERR);
    test_done();
  end
endmodule
